// >>> core/rtc_calendar_alarm_core.sv
// Clock/calendar core with two alarms, a combined output and a plain register port.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps

module rtc_calendar_alarm_core
    import rtc_core_pkg::*;
#(
    parameter int unsigned NV_CYCLES = NV_WRITE_CYCLES
) (
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic              xtal_in,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [7:0]        rdata,
    output logic                   freq_or_alarm_out
);

    typedef struct packed {
        logic [2:0]                xs;
        logic                      xl;
        logic [15:0]               acc;
        logic                      half;
        logic                      halted;
        logic                      rtcf;
        logic [7:0][7:0]           tm;
        logic [7:0][7:0]           hold;
        logic [1:0][7:0][7:0]      alm;
        logic [7:0]                int_ctrl;
        logic [1:0]                al;
        logic [1:0]                armed;
        logic [NV_CNT_W-1:0]       nv_cnt;
        logic                      seq;
        logic [2:0]                last_idx;
        logic [7:0]                rdata;
        logic                      out;
    } state_t;

    state_t st;
    state_t next_st;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] r;
        if (v == hi) begin
            r = lo;
        end else if (v[3:0] == 4'h9) begin
            r = {4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            r = 8'(v + 8'h01);
        end
        return r;
    endfunction

    // Years divisible by four in BCD: even tens with 0/4/8, odd tens with 2/6.
    function automatic logic is_leap(input logic [7:0] yr);
        logic l;
        if (!yr[4]) begin
            l = (yr[3:0] == 4'h0) || (yr[3:0] == 4'h4) || (yr[3:0] == 4'h8);
        end else begin
            l = (yr[3:0] == 4'h2) || (yr[3:0] == 4'h6);
        end
        return l;
    endfunction

    function automatic logic [7:0] last_date(input logic [7:0] mo, input logic [7:0] yr);
        logic [7:0] d;
        unique case (mo)
            8'h02: d = is_leap(yr) ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: d = 8'h30;
            default: d = 8'h31;
        endcase
        return d;
    endfunction

    // Returns the day carry in bit 8 and the new hour byte below it.
    function automatic logic [8:0] hour_inc(input logic [7:0] hr);
        logic [8:0] r;
        r = {1'b0, hr};
        if (hr[HR_MIL_BIT]) begin
            if (hr[5:0] == 6'h23) begin
                r = {1'b1, hr[7:6], 6'h00};
            end else begin
                r[7:0] = {hr[7:6], 6'(bcd_inc({2'h0, hr[5:0]}, 8'h00, 8'h23))};
            end
        end else if (hr[4:0] == 5'h12) begin
            r[4:0] = 5'h01;
        end else if (hr[4:0] == 5'h11) begin
            r[4:0] = 5'h12;
            r[HR_PM_BIT] = ~hr[HR_PM_BIT];
            r[8] = hr[HR_PM_BIT];
        end else begin
            r[4:0] = 5'(bcd_inc({3'h0, hr[4:0]}, 8'h01, 8'h12));
        end
        return r;
    endfunction

    always_comb begin
        logic        rise;
        logic        adv;
        logic [16:0] sum;
        logic        c_sec;
        logic        c_min;
        logic        c_hr;
        logic        c_day;
        logic        c_mo;
        logic [8:0]  hr_n;
        logic [1:0]  fire;
        logic        ok;
        logic        any_en;
        logic [2:0]  idx;
        logic        t_sel;
        logic        a_sel;
        logic        i_sel;
        logic        s_sel;
        logic        nv_free;
        logic        snap;
        logic [1:0]  al_irq;
        next_st = st;
        rise    = 1'b0;
        adv     = 1'b0;
        sum     = 17'h00000;
        c_sec   = 1'b0;
        c_min   = 1'b0;
        c_hr    = 1'b0;
        c_day   = 1'b0;
        c_mo    = 1'b0;
        hr_n    = 9'h000;
        fire    = 2'h0;
        ok      = 1'b0;
        any_en  = 1'b0;
        idx     = addr[2:0];
        t_sel   = (addr[15:3] == TIME_BASE[15:3]);
        a_sel   = (addr[15:4] == ALARM0_BASE[15:4]);
        i_sel   = (addr == INT_CTRL_ADDR);
        s_sel   = (addr == STATUS_ADDR);
        nv_free = (st.nv_cnt == '0);
        snap    = 1'b0;
        al_irq  = 2'h0;

        // Crystal level: three stages, a change counts once stages two and three agree.
        next_st.xs = {st.xs[1:0], xtal_in};
        if (st.xs[1] == st.xs[2]) begin
            next_st.xl = st.xs[2];
        end
        rise = st.xs[2] & st.xs[1] & ~st.xl;

        // Fractional divider: 32768 is no multiple of 200, so the error is spread over each 4096 crystal rises, an eighth of a second.
        sum = 17'({1'b0, st.acc} + 17'(HALF_TICK_HZ));
        if (!st.halted && rise) begin
            if (sum >= 17'(XTAL_HZ)) begin
                next_st.acc  = 16'(sum - 17'(XTAL_HZ));
                next_st.half = ~st.half;
                adv          = st.half;
            end else begin
                next_st.acc = sum[15:0];
            end
        end

        if (adv) begin
            c_sec = (st.tm[IDX_HUND] == 8'h99);
            next_st.tm[IDX_HUND] = bcd_inc(st.tm[IDX_HUND], 8'h00, 8'h99);
        end
        if (c_sec) begin
            c_min = (st.tm[IDX_SEC] == 8'h59);
            next_st.tm[IDX_SEC] = bcd_inc(st.tm[IDX_SEC], 8'h00, 8'h59);
        end
        if (c_min) begin
            next_st.tm[IDX_MIN] = bcd_inc(st.tm[IDX_MIN], 8'h00, 8'h59);
            c_hr = (st.tm[IDX_MIN] == 8'h59);
        end
        if (c_hr) begin
            hr_n = hour_inc(st.tm[IDX_HOUR]);
            next_st.tm[IDX_HOUR] = hr_n[7:0];
            c_day = hr_n[8];
        end
        if (c_day) begin
            next_st.tm[IDX_DOW] = (st.tm[IDX_DOW] == 8'h06) ? 8'h00 : 8'(st.tm[IDX_DOW] + 8'h01);
            c_mo = (st.tm[IDX_DATE] == last_date(st.tm[IDX_MONTH], st.tm[IDX_YEAR]));
            next_st.tm[IDX_DATE] = bcd_inc(st.tm[IDX_DATE], 8'h01,
                                           last_date(st.tm[IDX_MONTH], st.tm[IDX_YEAR]));
        end
        if (c_mo) begin
            next_st.tm[IDX_MONTH] = bcd_inc(st.tm[IDX_MONTH], 8'h01, 8'h12);
            if (st.tm[IDX_MONTH] == 8'h12) begin
                next_st.tm[IDX_YEAR] = bcd_inc(st.tm[IDX_YEAR], 8'h00, 8'h99);
            end
        end

        // Alarms compare against the live counters, never the read latch, so reads cannot disturb them.
        for (int a = 0; a < 2; a++) begin
            ok     = 1'b1;
            any_en = 1'b0;
            for (int k = 0; k < 8; k++) begin
                if (st.alm[a][k][ALM_EN_BIT]) begin
                    any_en = 1'b1;
                    ok     = ok & (st.alm[a][k][6:0] == next_st.tm[k][6:0]);
                end
            end
            fire[a] = c_sec & any_en & ok & st.armed[a];
            if (fire[a] && !st.int_ctrl[INT_IM_BIT]) begin
                next_st.armed[a] = 1'b0;
            end
        end

        if (!nv_free) begin
            next_st.nv_cnt = NV_CNT_W'(st.nv_cnt - 1'b1);
        end

        // The port takes a strobe on every clock edge with no wait state.
        if (wr) begin
            next_st.seq = 1'b0;
            if (t_sel) begin
                next_st.tm[idx] = wdata;
                if (idx != IDX_HUND) begin
                    next_st.tm[IDX_HUND] = 8'h00;
                end
                next_st.halted = 1'b0;
                next_st.rtcf   = 1'b0;
                next_st.acc    = 16'h0000;
                next_st.half   = 1'b0;
            end else if (a_sel && nv_free) begin
                next_st.alm[addr[3]][idx] = wdata;
                next_st.armed[addr[3]]    = 1'b1;
                next_st.nv_cnt            = NV_CNT_W'(NV_CYCLES);
            end else if (i_sel && nv_free) begin
                next_st.int_ctrl = wdata & INT_WR_MASK;
                next_st.armed    = 2'h3;
                next_st.nv_cnt   = NV_CNT_W'(NV_CYCLES);
            end else if (s_sel) begin
                next_st.al = st.al & {wdata[SR_AL1_BIT], wdata[SR_AL0_BIT]};
            end
        end
        // A match in the cycle of a clearing write still leaves its flag set.
        next_st.al = next_st.al | fire;

        next_st.rdata = 8'h00;
        if (rd) begin
            next_st.seq      = t_sel;
            next_st.last_idx = idx;
            if (t_sel) begin
                snap = !(st.seq && idx == 3'(st.last_idx + 3'h1));
                if (snap) begin
                    next_st.hold  = st.tm;
                    next_st.rdata = st.tm[idx];
                end else begin
                    next_st.rdata = st.hold[idx];
                end
            end else if (a_sel) begin
                next_st.rdata = st.alm[addr[3]][idx];
            end else if (i_sel) begin
                next_st.rdata = st.int_ctrl;
            end else if (s_sel) begin
                next_st.rdata[SR_AL1_BIT]    = st.al[1];
                next_st.rdata[SR_AL0_BIT]    = st.al[0];
                next_st.rdata[SR_NVBUSY_BIT] = !nv_free;
                next_st.rdata[SR_RTCF_BIT]   = st.rtcf;
            end
        end

        al_irq = st.al & {st.int_ctrl[INT_AL1E_BIT], st.int_ctrl[INT_AL0E_BIT]};
        unique case (fo_mode_t'(st.int_ctrl[INT_FO_LSB +: 2]))
            FO_ALARM: next_st.out = ~|al_irq;
            FO_32K:   next_st.out = st.xl;
            FO_100HZ: next_st.out = st.half;
            FO_1HZ:   next_st.out = (st.tm[IDX_HUND][7:4] < 4'h5);
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st                   <= '0;
            st.halted            <= 1'b1;
            st.rtcf              <= 1'b1;
            st.tm[IDX_HOUR]      <= HOUR_RESET;
            st.tm[IDX_DATE]      <= DATE_RESET;
            st.tm[IDX_MONTH]     <= MONTH_RESET;
            st.int_ctrl          <= INT_CTRL_RESET;
            st.armed             <= 2'h3;
            st.out               <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign rdata             = st.rdata;
    assign freq_or_alarm_out = st.out;

endmodule

// >>> include/rtc_core_pkg.sv
// Shared constants and types for the clock/calendar core.
package rtc_core_pkg;

    // Register map, 16-bit byte addresses.
    localparam int unsigned    ADDR_W          = 16;
    localparam logic [15:0]    ALARM0_BASE     = 16'h0000;
    localparam logic [15:0]    ALARM1_BASE     = 16'h0008;
    localparam logic [15:0]    INT_CTRL_ADDR   = 16'h0011;
    localparam logic [15:0]    TIME_BASE       = 16'h0030;
    localparam logic [15:0]    STATUS_ADDR     = 16'h003F;

    // Byte index of each field inside the time block and inside each alarm block.
    localparam logic [2:0]     IDX_SEC         = 3'h0;
    localparam logic [2:0]     IDX_MIN         = 3'h1;
    localparam logic [2:0]     IDX_HOUR        = 3'h2;
    localparam logic [2:0]     IDX_DATE        = 3'h3;
    localparam logic [2:0]     IDX_MONTH       = 3'h4;
    localparam logic [2:0]     IDX_YEAR        = 3'h5;
    localparam logic [2:0]     IDX_DOW         = 3'h6;
    localparam logic [2:0]     IDX_HUND        = 3'h7;

    // Field positions.
    localparam int unsigned    HR_MIL_BIT      = 7;
    localparam int unsigned    HR_PM_BIT       = 5;
    localparam int unsigned    ALM_EN_BIT      = 7;
    localparam int unsigned    INT_IM_BIT      = 7;
    localparam int unsigned    INT_AL1E_BIT    = 6;
    localparam int unsigned    INT_AL0E_BIT    = 5;
    localparam int unsigned    INT_FO_LSB      = 3;
    localparam logic [7:0]     INT_WR_MASK     = 8'hF8;
    localparam int unsigned    SR_AL1_BIT      = 6;
    localparam int unsigned    SR_AL0_BIT      = 5;
    localparam int unsigned    SR_NVBUSY_BIT   = 3;
    localparam int unsigned    SR_RTCF_BIT     = 0;

    // Reset values.
    localparam logic [7:0]     INT_CTRL_RESET  = 8'h00;
    localparam logic [7:0]     HOUR_RESET      = 8'h80;
    localparam logic [7:0]     DATE_RESET      = 8'h01;
    localparam logic [7:0]     MONTH_RESET     = 8'h01;

    // Timing.
    localparam int unsigned    CORE_CLK_HZ            = 20_000_000;
    localparam int unsigned    XTAL_HZ                = 32768;
    localparam int unsigned    HALF_TICK_HZ           = 200;
    localparam int unsigned    NV_WRITE_CYCLE_TIME_MS = 10;
    localparam int unsigned    NV_WRITE_CYCLES        = NV_WRITE_CYCLE_TIME_MS * (CORE_CLK_HZ / 1000);
    localparam int unsigned    POWERUP_TO_READ_DELAY_MS  = 1;
    localparam int unsigned    POWERUP_TO_WRITE_DELAY_MS = 5;
    localparam int unsigned    NV_CNT_W               = 18;

    // Selection of the combined frequency or alarm output.
    typedef enum logic [1:0] {
        FO_ALARM = 2'h0,
        FO_32K   = 2'h1,
        FO_100HZ = 2'h2,
        FO_1HZ   = 2'h3
    } fo_mode_t;

endpackage

// >>> dv/xtal_model.sv
// Free-running crystal source standing in for the oscillator.
`timescale 1ns/1ps
module xtal_model (
    output logic xtal
);
    // The crystal runs free from time zero; there is no framing on this input.
    initial xtal = 1'b0;
    always #200 xtal = ~xtal;
endmodule

// >>> dv/rtc_core_properties.sv
// Port-level assertions for the clock/calendar core.
`timescale 1ns/1ps
module rtc_core_properties
    import rtc_core_pkg::*;
#(
    parameter int unsigned NV_CYCLES = NV_WRITE_CYCLES
) (
    input wire logic              core_clk,
    input wire logic              resetn,
    input wire logic              xtal_in,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [7:0]        wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [7:0]        rdata,
    input wire logic              freq_or_alarm_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    sequence s_rd_at(logic [15:0] a);
        rd && addr == a;
    endsequence
    a_reset_idle: assert property ($rose(resetn) |-> rdata == 8'h00 && freq_or_alarm_out)
        else $error("outputs not idle after reset");
    a_rdata_one_cycle: assert property (!rd |=> rdata == 8'h00)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (rd && addr > STATUS_ADDR |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_ctrl_low_bits: assert property (s_rd_at(INT_CTRL_ADDR) |=> rdata[2:0] == 3'h0)
        else $error("control low bits not zero");
    a_status_spare: assert property (s_rd_at(STATUS_ADDR) |=> rdata[7] == 1'b0 && rdata[4] == 1'b0)
        else $error("status spare bits set");
    a_sec_bcd: assert property (s_rd_at(TIME_BASE) |=> rdata[7] == 1'b0 && rdata[3:0] <= 4'h9)
        else $error("seconds not valid BCD");
    a_date_range: assert property (s_rd_at(16'h0033) |=> rdata[7:6] == 2'h0 && rdata != 8'h00)
        else $error("date out of range");
    a_month_range: assert property (s_rd_at(16'h0034) |=> rdata inside {[8'h01:8'h09], [8'h10:8'h12]})
        else $error("month out of range");
    a_dow_range: assert property (s_rd_at(16'h0036) |=> rdata <= 8'h06)
        else $error("day of week out of range");
endmodule
bind rtc_calendar_alarm_core rtc_core_properties #(.NV_CYCLES(NV_CYCLES)) u_props (
    .core_clk(core_clk), .resetn(resetn), .xtal_in(xtal_in), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .freq_or_alarm_out(freq_or_alarm_out));

// >>> dv/tb_top.sv
// Self-checking bench for the clock/calendar core.
`timescale 1ns/1ps
module tb_top;
    import rtc_core_pkg::*;
    logic        core_clk;
    logic        resetn;
    wire         xtal_in;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        freq_or_alarm_out;
    logic [7:0]  got;
    int          fail_count;
    int          samples_checked;
    int          cycles;

    xtal_model u_xtal (.xtal(xtal_in));
    // A short write cycle keeps the run brief; the busy flag is polled, never timed.
    rtc_calendar_alarm_core #(.NV_CYCLES(20)) u_dut (
        .core_clk(core_clk), .resetn(resetn), .xtal_in(xtal_in), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .freq_or_alarm_out(freq_or_alarm_out));

    always #25 core_clk = ~core_clk;

    task automatic stop_test;
        if (fail_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            stop_test;
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
            fail_count++;
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic wait_reg(input logic [15:0] a, input logic [7:0] e);
        int n;
        n = 0;
        rd_reg(a, got);
        while (got !== e && n < 6000) begin
            rd_reg(a, got);
            n++;
        end
        chk(got, e);
    endtask

    task automatic wait_nv;
        int n;
        n = 0;
        rd_reg(STATUS_ADDR, got);
        while (got[SR_NVBUSY_BIT] !== 1'b0 && n < 100) begin
            rd_reg(STATUS_ADDR, got);
            n++;
        end
        chk({7'h00, got[SR_NVBUSY_BIT]}, 8'h00);
    endtask

    task automatic t_reset;
        rd_reg(STATUS_ADDR, got);
        chk(got, 8'h01);
        rd_reg(16'h0032, got);
        chk(got, HOUR_RESET);
        rd_reg(INT_CTRL_ADDR, got);
        chk(got, INT_CTRL_RESET);
        rd_reg(16'h0036, got);
        chk(got, 8'h00);
        rd_reg(16'h0040, got);
        chk(got, 8'h00);
        // The crystal runs all along, so a moving count here means the halt failed.
        repeat (6000) @(posedge core_clk);
        rd_reg(16'h0037, got);
        chk(got, 8'h00);
    endtask

    task automatic t_alarm_carry;
        wr_reg(ALARM0_BASE, 8'h80);
        // Control writes are refused while the alarm write is still busy, so poll in between.
        wait_nv();
        wr_reg(INT_CTRL_ADDR, 8'h20);
        wait_nv();
        wr_reg(16'h0030, 8'h59);
        wr_reg(16'h0037, 8'h98);
        wait_reg(16'h0030, 8'h00);
        @(posedge core_clk);
        #1 chk({7'h00, freq_or_alarm_out}, 8'h00);
        rd_reg(16'h0031, got);
        chk(got, 8'h01);
        rd_reg(STATUS_ADDR, got);
        chk(got, 8'h20);
        chk({7'h00, freq_or_alarm_out}, 8'h00);
        wr_reg(STATUS_ADDR, 8'h00);
        rd_reg(STATUS_ADDR, got);
        chk(got, 8'h00);
        chk({7'h00, freq_or_alarm_out}, 8'h01);
    endtask

    task automatic t_rollover(input logic [7:0] y, input logic [7:0] m, input logic [7:0] d,
                              input logic [7:0] ed, input logic [7:0] em);
        logic [15:0] a[7];
        logic [7:0]  v[7];
        a = '{16'h0035, 16'h0034, 16'h0033, 16'h0032, 16'h0031, 16'h0030, 16'h0037};
        v = '{y, m, d, 8'hA3, 8'h59, 8'h59, 8'h98};
        for (int i = 0; i < 7; i++) begin
            wr_reg(a[i], v[i]);
        end
        wait_reg(16'h0032, 8'h80);
        rd_reg(16'h0033, got);
        chk(got, ed);
        rd_reg(16'h0034, got);
        chk(got, em);
    endtask

    task automatic count_rises(input int len, output int n);
        logic prev;
        n    = 0;
        prev = freq_or_alarm_out;
        repeat (len) begin
            @(posedge core_clk);
            #1;
            if (freq_or_alarm_out && !prev)
                n++;
            prev = freq_or_alarm_out;
        end
    endtask

    task automatic t_freq;
        int n;
        n = 0;
        wr_reg(INT_CTRL_ADDR, 8'h08);
        wait_nv();
        count_rises(800, n);
        chk({7'h00, n >= 95 && n <= 105}, 8'h01);
        wr_reg(INT_CTRL_ADDR, 8'h10);
        wait_nv();
        // At the bench crystal rate one 100 Hz period spans about 2621 cycles.
        count_rises(5300, n);
        chk({7'h00, n >= 2 && n <= 3}, 8'h01);
        wr_reg(INT_CTRL_ADDR, 8'h18);
        wait_nv();
        rd_reg(16'h0037, got);
        chk({7'h00, freq_or_alarm_out}, {7'h00, got < 8'h50});
    endtask

    task automatic t_repeat;
        wr_reg(ALARM1_BASE, 8'h80);
        wait_nv();
        wr_reg(INT_CTRL_ADDR, 8'hC0);
        wait_nv();
        // Alarm 0 still matches second zero and the control write re-armed it as well.
        repeat (2) begin
            wr_reg(16'h0030, 8'h59);
            wr_reg(16'h0037, 8'h98);
            wait_reg(16'h0030, 8'h00);
            rd_reg(STATUS_ADDR, got);
            chk(got, 8'h60);
            chk({7'h00, freq_or_alarm_out}, 8'h00);
            wr_reg(STATUS_ADDR, 8'h00);
        end
    endtask

    task automatic power_cycle;
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        // A scaled-down power-up wait stands for the host's delay before its first access.
        repeat (20) @(posedge core_clk);
    endtask

    initial begin
        core_clk = 1'b0;
        resetn   = 1'b0;
        addr     = 16'h0000;
        wdata    = 8'h00;
        wr       = 1'b0;
        rd       = 1'b0;
        power_cycle();
        t_reset();
        t_alarm_carry();
        t_rollover(8'h24, 8'h02, 8'h28, 8'h29, 8'h02);
        t_rollover(8'h23, 8'h02, 8'h28, 8'h01, 8'h03);
        t_rollover(8'h23, 8'h04, 8'h30, 8'h01, 8'h05);
        t_freq();
        t_repeat();
        // Losing both supplies in mid-run must bring back the halted reset state.
        power_cycle();
        t_reset();
        stop_test;
    end
endmodule
